// *** amc_accu_motion_exec.sv ***
// Operation
// - a velocity taken from the accumulator is passed on unchanged as microsteps per second.
// - instruction 50 selects velocity mode and loads the accumulator into parameter 2, down.
// - instruction 51 selects velocity mode and loads the accumulator into parameter 2, up.
// - rotations with explicit axis take axis 0 to 2 from the bank byte, type and value ignored.
// - instruction 52 rotates down on the axis in the X register, frame fields ignored.
// - instruction 53 rotates up on the axis in the X register, frame fields ignored.
// - instruction 47 type 0 is absolute, 1 relative, 2 stored coordinate; bank, value ignored.
// - positioning writes the target into parameter 0 of the axis in the X register.
// - positioning replies at once and further commands are taken while the motor moves.
// - a later rotation overrides a positioning move in progress.
// - position arithmetic wraps at 32 bits; the host keeps distances within 2147483647.
// - relative positioning adds the accumulator to the axis's actual position.
// - coordinate positioning moves to the axis's stored coordinate.
// - a frame is address, instruction, type, bank, four value bytes msb first, checksum.
`timescale 1ns/1ps
`default_nettype none

module amc_accu_motion_exec #(
   parameter logic [7:0] MODULE_ADDR = 8'h01,
   parameter int         AXES        = 3
) (
   input  wire logic                   clock,
   input  wire logic                   rst,
   input  wire logic                   ce,
   input  wire logic [7:0]             rx_byte,
   input  wire logic                   rx_valid,
   input  wire logic [31:0]            accu,
   input  wire logic [31:0]            xreg,
   input  wire logic [AXES-1:0][31:0]  actual_pos,
   input  wire logic [AXES-1:0][31:0]  stored_point,
   output var amc_pkg::amc_cmd_type    axis_cmd,
   output logic                        axis_cmd_valid,
   output var amc_pkg::amc_reply_type  reply,
   output logic                        reply_valid
);
   // ****************************************************************
   // parameter check
   // ****************************************************************
   if (AXES != 3) begin : g_axes_check
      $error("axis count must be 3");
   end

   // ****************************************************************
   // frame intake
   // ****************************************************************
   amc_pkg::amc_frame_type frame;
   logic                   frame_valid;

   amc_frame_rx u_rx (
      .clock       (clock),
      .rst         (rst),
      .ce          (ce),
      .rx_byte     (rx_byte),
      .rx_valid    (rx_valid),
      .frame       (frame),
      .frame_valid (frame_valid)
   );

   // ****************************************************************
   // decode and execute
   // ****************************************************************
   typedef enum logic {S_IDLE, S_EXEC} amc_state_type;

   amc_state_type           state_reg,  state_next;
   amc_pkg::amc_frame_type  hold_reg,   hold_next;
   amc_pkg::amc_cmd_type    cmd_reg,    cmd_next;
   logic                    cv_reg,     cv_next;
   amc_pkg::amc_reply_type  rep_reg,    rep_next;
   logic                    rv_reg,     rv_next;

   logic [1:0]  ax_bank;
   logic [1:0]  ax_x;
   logic        bank_ok;
   logic        x_ok;

   // axis range checks; x register out of range is refused, not truncated
   assign ax_bank = hold_reg.bank[1:0];
   assign ax_x    = xreg[1:0];
   assign bank_ok = (hold_reg.bank[7:2] == 6'h00) && (ax_bank <= amc_pkg::AXIS_MAX);
   assign x_ok    = (xreg[31:2] == 30'h0) && (ax_x <= amc_pkg::AXIS_MAX);

   always_comb begin
      state_next = state_reg;
      hold_next  = hold_reg;
      cmd_next   = cmd_reg;
      cv_next    = 1'b0;
      rep_next   = rep_reg;
      rv_next    = 1'b0;
      case (state_reg)
         S_IDLE: begin
            // frames for other addresses pass silently
            if (frame_valid && frame.addr == MODULE_ADDR) begin
               hold_next  = frame;
               state_next = S_EXEC;
            end
         end
         default: begin
            state_next     = S_IDLE;
            rv_next        = 1'b1;
            rep_next.addr  = MODULE_ADDR;
            rep_next.instr = hold_reg.instr;
            rep_next.value = 32'h0000_0000;
            rep_next.status = amc_pkg::ST_OK;
            cmd_next.value  = accu;
            cmd_next.mode   = amc_pkg::MODE_VELOCITY;
            cmd_next.param  = amc_pkg::PARAM_TGT_VEL;
            cmd_next.dir_up = 1'b0;
            cmd_next.axis   = ax_x;
            if (!hold_reg.sum_ok) begin
               rep_next.status = amc_pkg::ST_BAD_SUM;
            end else if (hold_reg.instr == amc_pkg::INS_ROT_DN ||
                         hold_reg.instr == amc_pkg::INS_ROT_UP) begin
               cmd_next.axis   = ax_bank;
               cmd_next.dir_up = (hold_reg.instr == amc_pkg::INS_ROT_UP);
               if (bank_ok) begin
                  cv_next = 1'b1;
               end else begin
                  rep_next.status = amc_pkg::ST_BAD_VALUE;
               end
            end else if (hold_reg.instr == amc_pkg::INS_ROT_DN_X ||
                         hold_reg.instr == amc_pkg::INS_ROT_UP_X) begin
               cmd_next.dir_up = (hold_reg.instr == amc_pkg::INS_ROT_UP_X);
               if (x_ok) begin
                  cv_next = 1'b1;
               end else begin
                  rep_next.status = amc_pkg::ST_BAD_VALUE;
               end
            end else if (hold_reg.instr == amc_pkg::INS_MOVE_XREG) begin
               cmd_next.mode  = amc_pkg::MODE_POSITION;
               cmd_next.param = amc_pkg::PARAM_TGT_POS;
               // direction is left to the ramp unit, which takes the short way
               cmd_next.dir_up = 1'b0;
               if (!x_ok) begin
                  rep_next.status = amc_pkg::ST_BAD_VALUE;
               end else if (hold_reg.typ == amc_pkg::TYPE_ABSOLUTE_TARGET) begin
                  cv_next = 1'b1;
               end else if (hold_reg.typ == amc_pkg::TYPE_RELATIVE_OFFSET_TARGET) begin
                  cmd_next.value = actual_pos[ax_x] + accu;
                  cv_next        = 1'b1;
               end else if (hold_reg.typ == amc_pkg::TYPE_STORED_POINT_TARGET) begin
                  cmd_next.value = stored_point[ax_x];
                  cv_next        = 1'b1;
               end else begin
                  rep_next.status = amc_pkg::ST_BAD_TYPE;
               end
            end else begin
               rep_next.status = amc_pkg::ST_BAD_CMD;
            end
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_reg <= S_IDLE;
         hold_reg  <= '0;
         cmd_reg   <= '0;
         cv_reg    <= 1'b0;
         rep_reg   <= '0;
         rv_reg    <= 1'b0;
      end else if (ce) begin
         state_reg <= state_next;
         hold_reg  <= hold_next;
         cmd_reg   <= cmd_next;
         cv_reg    <= cv_next;
         rep_reg   <= rep_next;
         rv_reg    <= rv_next;
      end
   end

   assign axis_cmd       = cmd_reg;
   assign axis_cmd_valid = cv_reg;
   assign reply          = rep_reg;
   assign reply_valid    = rv_reg;
endmodule

`default_nettype wire

// *** amc_frame_rx.sv ***
// ****************************************************************
// shared constants and carriers
// ****************************************************************
package amc_pkg;
   localparam int          FRAME_BYTES    = 9;
   localparam logic [7:0]  INS_MOVE_XREG  = 8'h2F;
   localparam logic [7:0]  INS_ROT_DN     = 8'h32;
   localparam logic [7:0]  INS_ROT_UP     = 8'h33;
   localparam logic [7:0]  INS_ROT_DN_X   = 8'h34;
   localparam logic [7:0]  INS_ROT_UP_X   = 8'h35;
   localparam logic [7:0]  TYPE_ABSOLUTE_TARGET         = 8'h00;
   localparam logic [7:0]  TYPE_RELATIVE_OFFSET_TARGET  = 8'h01;
   localparam logic [7:0]  TYPE_STORED_POINT_TARGET     = 8'h02;
   localparam logic [7:0]  PARAM_TGT_POS  = 8'h00;
   localparam logic [7:0]  PARAM_TGT_VEL  = 8'h02;
   localparam logic [7:0]  ST_OK          = 8'h64;
   localparam logic [7:0]  ST_BAD_SUM     = 8'h01;
   localparam logic [7:0]  ST_BAD_CMD     = 8'h02;
   localparam logic [7:0]  ST_BAD_TYPE    = 8'h03;
   localparam logic [7:0]  ST_BAD_VALUE   = 8'h04;
   localparam logic [1:0]  AXIS_MAX       = 2'h2;
   localparam logic [3:0]  CNT_LAST       = 4'h8;

   typedef struct packed {
      logic [7:0]  addr;
      logic [7:0]  instr;
      logic [7:0]  typ;
      logic [7:0]  bank;
      logic [31:0] value;
      logic        sum_ok;
   } amc_frame_type;

   typedef enum logic {MODE_VELOCITY, MODE_POSITION} amc_mode_type;

   typedef struct packed {
      logic [1:0]   axis;
      amc_mode_type mode;
      logic [7:0]   param;
      logic [31:0]  value;
      logic         dir_up;
   } amc_cmd_type;

   typedef struct packed {
      logic [7:0]  addr;
      logic [7:0]  status;
      logic [7:0]  instr;
      logic [31:0] value;
   } amc_reply_type;
endpackage

`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// frame assembler with running checksum
// ****************************************************************
module amc_frame_rx (
   input  wire logic           clock,
   input  wire logic           rst,
   input  wire logic           ce,
   input  wire logic [7:0]     rx_byte,
   input  wire logic           rx_valid,
   output var amc_pkg::amc_frame_type frame,
   output logic                frame_valid
);
   logic [3:0]              cnt_reg,   cnt_next;
   logic [7:0]              sum_reg,   sum_next;
   amc_pkg::amc_frame_type  fr_reg,    fr_next;
   logic                    fv_reg,    fv_next;

   always_comb begin
      cnt_next = cnt_reg;
      sum_next = sum_reg;
      fr_next  = fr_reg;
      fv_next  = 1'b0;
      if (rx_valid) begin
         // address, instr, type, bank, value msb first, checksum
         case (cnt_reg)
            4'h0: fr_next.addr  = rx_byte;
            4'h1: fr_next.instr = rx_byte;
            4'h2: fr_next.typ   = rx_byte;
            4'h3: fr_next.bank  = rx_byte;
            4'h4, 4'h5, 4'h6, 4'h7: fr_next.value = {fr_reg.value[23:0], rx_byte};
            default: fr_next.sum_ok = (rx_byte == sum_reg);
         endcase
         // sum wraps mod 256 by width
         sum_next = (cnt_reg == amc_pkg::CNT_LAST) ? 8'h00 : sum_reg + rx_byte;
         if (cnt_reg == amc_pkg::CNT_LAST) begin
            cnt_next = 4'h0;
            fv_next  = 1'b1;
         end else begin
            cnt_next = cnt_reg + 4'h1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         cnt_reg <= 4'h0;
         sum_reg <= 8'h00;
         fr_reg  <= '0;
         fv_reg  <= 1'b0;
      end else if (ce) begin
         cnt_reg <= cnt_next;
         sum_reg <= sum_next;
         fr_reg  <= fr_next;
         fv_reg  <= fv_next;
      end
   end

   assign frame       = fr_reg;
   assign frame_valid = fv_reg;
endmodule

`default_nettype wire

// *** amc_exec_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// reply and command relations
// ****************************************
module amc_exec_props #(
   parameter logic [7:0] MODULE_ADDR = 8'h01,
   parameter int         AXES        = 3
) (
   input wire logic                   clock,
   input wire logic                   rst,
   input wire logic [31:0]            accu,
   input wire logic [31:0]            xreg,
   input wire amc_pkg::amc_cmd_type   axis_cmd,
   input wire logic                   axis_cmd_valid,
   input wire amc_pkg::amc_reply_type reply,
   input wire logic                   reply_valid
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_cmd;
      axis_cmd_valid && reply_valid;
   endsequence
   sequence s_vel;
      s_cmd ##0 axis_cmd.mode == amc_pkg::MODE_VELOCITY;
   endsequence
   chk_cmd_is_ok: assert property (axis_cmd_valid |-> reply.status == amc_pkg::ST_OK)
      else $error("command without ok reply");
   chk_ok_has_cmd: assert property (reply_valid && reply.status == amc_pkg::ST_OK |-> s_cmd)
      else $error("ok reply without command");
   // ce is held high by the bench, so nine bytes separate two replies
   chk_reply_gap: assert property (reply_valid |=> !reply_valid [*8])
      else $error("replies closer than one frame");
   chk_vel_param: assert property (s_vel |->
      axis_cmd.param == amc_pkg::PARAM_TGT_VEL && axis_cmd.value == $past(accu))
      else $error("rotation parameter or speed wrong");
   chk_vel_dir: assert property (s_vel |-> axis_cmd.dir_up == reply.instr[0])
      else $error("rotation direction wrong");
   chk_pos_param: assert property (s_cmd ##0 axis_cmd.mode == amc_pkg::MODE_POSITION |->
      axis_cmd.param == amc_pkg::PARAM_TGT_POS && reply.instr == amc_pkg::INS_MOVE_XREG)
      else $error("positioning parameter wrong");
   chk_x_axis: assert property (s_cmd ##0 reply.instr[7:1] != 7'h19 |->
      axis_cmd.axis == 2'($past(xreg)))
      else $error("axis not taken from x register");
   chk_reply_addr: assert property (reply_valid |-> reply.addr == MODULE_ADDR)
      else $error("reply address wrong");
endmodule
bind amc_accu_motion_exec amc_exec_props #(.MODULE_ADDR(MODULE_ADDR), .AXES(AXES)) i_props (
   .clock(clock), .rst(rst), .accu(accu), .xreg(xreg), .axis_cmd(axis_cmd),
   .axis_cmd_valid(axis_cmd_valid), .reply(reply), .reply_valid(reply_valid));
`default_nettype wire

// *** amc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// host sending command frames
// ****************************************
module amc_host_model (
   input  wire logic  clock,
   output var logic [7:0] rx_byte,
   output var logic       rx_valid
);
   initial begin
      rx_byte = 8'h00;
      rx_valid = 1'b0;
   end
   // no release at the end, so two calls give back-to-back frames
   task automatic send(input logic [63:0] f, input logic bad);
      logic [7:0] s;
      s = 8'h00;
      for (int i = 7; i >= 0; i--) begin
         @(negedge clock);
         rx_byte = f[i*8 +: 8];
         rx_valid = 1'b1;
         s = s + rx_byte;
      end
      @(negedge clock);
      rx_byte = s ^ {8{bad}};
   endtask
   // released line shows the inverse, never a stale byte
   task automatic idle();
      @(negedge clock);
      rx_valid = 1'b0;
      rx_byte = ~rx_byte;
   endtask
endmodule
`default_nettype wire

// *** tb_accu_motion_command_exec.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_accu_motion_command_exec;
   typedef struct packed {
      logic [7:0] ins, typ, bank, xr, st;
      logic [1:0] ax;
      logic [31:0] val;
      logic up;
   } amc_row_type;
   typedef struct packed {
      amc_pkg::amc_reply_type rp;
      logic                   v;
      amc_pkg::amc_cmd_type   c;
   } amc_obs_type;
   localparam logic [7:0] ST = amc_pkg::ST_OK;
   localparam logic [31:0] A = 32'h0000_0020;
   logic                    clock = 1'b0;
   logic                    rst;
   logic [7:0]              rx_byte;
   logic                    rx_valid;
   logic [31:0]             accu, xreg;
   logic [2:0][31:0]        actual_pos, stored_point;
   amc_pkg::amc_cmd_type    axis_cmd;
   logic                    axis_cmd_valid;
   amc_pkg::amc_reply_type  reply;
   logic                    reply_valid;
   amc_obs_type             q[$];
   amc_row_type             rows[11];
   int                      num_errors = 0;
   int                      tests_run = 0;
// ****************************************
// clock, parts and helpers
// ****************************************
   always #25 clock = ~clock;
   amc_host_model i_host (.clock(clock), .rx_byte(rx_byte), .rx_valid(rx_valid));
   // ce tied high: freezing is not exercised here
   amc_accu_motion_exec #(.MODULE_ADDR(8'h01), .AXES(3)) i_dut (
      .clock(clock), .rst(rst), .ce(1'b1), .rx_byte(rx_byte), .rx_valid(rx_valid),
      .accu(accu), .xreg(xreg), .actual_pos(actual_pos), .stored_point(stored_point),
      .axis_cmd(axis_cmd), .axis_cmd_valid(axis_cmd_valid), .reply(reply),
      .reply_valid(reply_valid));
   // sampled mid-cycle, well away from the edge that launches the outputs
   always @(negedge clock) if (reply_valid === 1'b1) q.push_back({reply, axis_cmd_valid, axis_cmd});
   task automatic stop_test();
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [127:0] s, input logic [127:0] e);
      tests_run++;
      if (s !== e) begin
         num_errors++;
         $display("wrong value %s expected %0h seen %0h", nm, e, s);
      end
   endtask
   task automatic await(input int n);
      for (int i = 0; i < 12; i++) @(negedge clock);
      check("reply count", 128'(q.size()), 128'(n));
      if (q.size() != n) stop_test();
   endtask
   task automatic cmp(input amc_row_type r);
      amc_obs_type o;
      logic p;
      p = (r.ins == amc_pkg::INS_MOVE_XREG);
      o = q.pop_front();
      check("status", o.rp.status, r.st);
      check("instr", o.rp.instr, r.ins);
      check("reply addr", o.rp.addr, 8'h01);
      check("cmd valid", o.v, r.st == ST);
      if (r.st == ST) check("axis cmd", o.c, {r.ax, p, p ? 8'h00 : 8'h02, r.val, r.up});
   endtask
   task automatic run(input amc_row_type r, input logic [7:0] ad, input logic bad);
      xreg = {24'h0, r.xr};
      i_host.send({ad, r.ins, r.typ, r.bank, 32'hA5A5_0F0F}, bad);
      i_host.idle();
   endtask
// ****************************************
// main sequence
// ****************************************
   initial begin
      rst = 1'b1;
      accu = A;
      xreg = 32'h0;
      actual_pos = {32'hFFFF_FFF0, 32'h0000_0100, 32'h0000_0200};
      stored_point = {32'h0300_0000, 32'h0200_0000, 32'h1234_5678};
      rows = '{'{8'h32, 8'h07, 8'h00, 8'h02, ST, 2'h0, A, 1'b0},
               '{8'h33, 8'h00, 8'h02, 8'h00, ST, 2'h2, A, 1'b1},
               '{8'h34, 8'h05, 8'h02, 8'h01, ST, 2'h1, A, 1'b0},
               '{8'h35, 8'h00, 8'h00, 8'h02, ST, 2'h2, A, 1'b1},
               '{8'h2F, 8'h00, 8'h01, 8'h01, ST, 2'h1, A, 1'b0},
               '{8'h2F, 8'h01, 8'h00, 8'h02, ST, 2'h2, 32'h10, 1'b0},
               '{8'h2F, 8'h02, 8'h00, 8'h00, ST, 2'h0, 32'h1234_5678, 1'b0},
               '{8'h2F, 8'h03, 8'h00, 8'h00, 8'h03, 2'h0, A, 1'b0},
               '{8'h32, 8'h00, 8'h03, 8'h00, 8'h04, 2'h0, A, 1'b0},
               '{8'h35, 8'h00, 8'h00, 8'h03, 8'h04, 2'h0, A, 1'b0},
               '{8'h2E, 8'h00, 8'h00, 8'h00, 8'h02, 2'h0, A, 1'b0}};
      repeat (10) @(negedge clock);
      rst = 1'b0;
      @(negedge clock);
      check("reset outs", {reply_valid, axis_cmd_valid, reply, axis_cmd}, '0);
      foreach (rows[i]) begin
         run(rows[i], 8'h01, 1'b0);
         await(1);
         cmp(rows[i]);
      end
      // positioning overridden by a rotation sent back to back
      // both frames use axis 2, so xreg may change at the checksum edge
      xreg = 32'h2;
      i_host.send({8'h01, 8'h2F, 16'h0, 32'h0}, 1'b0);
      run(rows[3], 8'h01, 1'b0);
      await(2);
      cmp('{8'h2F, 8'h00, 8'h00, 8'h02, ST, 2'h2, A, 1'b0});
      cmp(rows[3]);
      run(rows[1], 8'h01, 1'b1);
      await(1);
      cmp('{8'h33, 8'h00, 8'h02, 8'h00, 8'h01, 2'h0, A, 1'b0});
      // reset in mid frame: the cut frame leaves no trace, counter restarts
      fork
         i_host.send({8'h01, 8'h33, 8'h00, 8'h02, 32'h0}, 1'b0);
      join_none
      repeat (4) @(negedge clock);
      rst = 1'b1;
      repeat (5) @(negedge clock);
      i_host.idle();
      rst = 1'b0;
      @(negedge clock);
      check("reset outs", {reply_valid, axis_cmd_valid, reply, axis_cmd}, '0);
      run(rows[3], 8'h01, 1'b0);
      await(1);
      cmp(rows[3]);
      run(rows[1], 8'h02, 1'b0);
      await(0);
      stop_test();
   end
   initial begin
      repeat (5000) @(posedge clock);
      num_errors++;
      stop_test();
   end
endmodule
`default_nettype wire
